// File: hdl/seph_pause.sv
// Pause (hold) tracker for the serial link
`timescale 1ns/1ps
module seph_pause (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_sel_n,
    input  wire logic i_sck,
    input  wire logic i_hold_n,
    output logic      o_paused
);
    logic paused_reg;
    logic sck_q_reg;
    logic sck_fall;

    assign sck_fall = sck_q_reg & ~i_sck;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sck_q_reg <= 1'b0;
        end else begin
            sck_q_reg <= i_sck;
        end
    end

    // Hold follows the pin only when clock is low, or at its falling edge; deselect clears it at any time
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_sel_n) begin
            paused_reg <= 1'b0;
        end else if (!i_sck || sck_fall) begin
            paused_reg <= ~i_hold_n;
        end
    end

    assign o_paused = paused_reg;
endmodule

// File: hdl/seph_pkg.sv
// Constants and types shared by the write-protect and write engine logic
package seph_pkg;

    // ------------------------------------------------------------
    // Address map and protect-size encodings
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 16;
    localparam logic [1:0] PSZ_NONE = 2'h0;
    localparam logic [1:0] PSZ_QTR  = 2'h1;
    localparam logic [1:0] PSZ_HALF = 2'h2;
    localparam logic [1:0] PSZ_ALL  = 2'h3;
    localparam logic [15:0] PROT_QTR_BASE  = 16'hC000;
    localparam logic [15:0] PROT_HALF_BASE = 16'h8000;
    localparam logic [15:0] PROT_ALL_BASE  = 16'h0000;

    // ------------------------------------------------------------
    // Status field reset values
    // ------------------------------------------------------------
    localparam logic       LOCK_RST = 1'b0;
    localparam logic [1:0] PSZ_RST  = 2'h0;

    // ------------------------------------------------------------
    // Write engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEPH_IDLE,
        SEPH_MEM_WR,
        SEPH_STS_WR
    } seph_wr_state_t;

endpackage

// File: hdl/seph_top.sv
// Write-protect decision, status lock fields, write engine and pause gating
`timescale 1ns/1ps
// Functional notes
// - Lock bit 0: status writable whenever enable latch is set.
// - Lock bit 1 and protect pin high: status writes still accepted.
// - Lock bit 1 and protect pin low: status writes refused.
// - Protect pin high releases hardware lock; only protect-size applies.
// - Protect-size 00 none, 01 C000-FFFF, 10 8000-FFFF, 11 all.
// - Latch clear blocks all writes; protected block never writable.
// - Paused: output floats, serial input and clock ignored.
// - Deselect during pause ends the operation in progress.
// - Pause input change with clock low acts immediately.
// - Pause input change with clock high acts at next falling edge.
// - Low supply aborts writes in progress and clears enable latch.
// - No write is started or taken while deselected.
// - Serial output is three-state: high, low or released.
// - Memory write into the protected range is neither accepted nor run.
// - Status write in hardware lock mode is not executed.
// - Lock and protect-size take new values only when status write ends.
module seph_top (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sel_n,
    input  wire logic        i_sck,
    input  wire logic        i_sdi,
    input  wire logic        i_hold_n,
    input  wire logic        i_wp_n,
    input  wire logic        i_low_supply,
    input  wire logic        i_set_wel,
    input  wire logic        i_clr_wel,
    input  wire logic        i_mem_wr_req,
    input  wire logic [15:0] i_mem_wr_addr,
    input  wire logic        i_sts_wr_req,
    input  wire logic        i_sts_lock_new,
    input  wire logic [1:0]  i_sts_psz_new,
    input  wire logic        i_wr_done,
    input  wire logic        i_sdo_data,
    input  wire logic        i_sdo_drive,
    output logic             o_sck_int,
    output logic             o_sdi_int,
    output logic             o_sdo,
    output logic             o_sdo_oe,
    output logic             o_paused,
    output logic             o_sel_end,
    output logic             o_write_enable_latch,
    output logic             o_status_lock_bit,
    output logic             o_protect_size_hi,
    output logic             o_protect_size_lo,
    output logic             o_hardware_lock_mode,
    output logic             o_software_lock_mode,
    output logic             o_wr_busy,
    output logic             o_mem_wr_go,
    output logic             o_sts_wr_go,
    output logic             o_wr_refused,
    output logic             o_wr_abort
);
    // ------------------------------------------------------------
    // Functions and state
    // ------------------------------------------------------------
    function automatic logic addr_protected(input logic [1:0] psz, input logic [15:0] a);
        logic r;
        r = 1'b0;
        case (psz)
            seph_pkg::PSZ_NONE: r = 1'b0;
            seph_pkg::PSZ_QTR:  r = (a >= seph_pkg::PROT_QTR_BASE);
            seph_pkg::PSZ_HALF: r = (a >= seph_pkg::PROT_HALF_BASE);
            seph_pkg::PSZ_ALL:  r = (a >= seph_pkg::PROT_ALL_BASE);
            default:            r = 1'b1;
        endcase
        return r;
    endfunction

    seph_pkg::seph_wr_state_t st_reg;
    logic       wel_reg;
    logic       lock_reg;
    logic [1:0] psz_reg;
    logic       pend_lock_reg;
    logic [1:0] pend_psz_reg;
    logic       paused;
    logic       sel_q_reg;
    logic       sck_int_reg;
    logic       sdi_int_reg;
    logic       sdo_reg;
    logic       sdo_oe_reg;
    logic       sel_end_reg;
    logic       hw_lock_reg;
    logic       mem_go_reg;
    logic       sts_go_reg;
    logic       refused_reg;
    logic       abort_reg;
    logic       busy_reg;
    logic       sw_lock_reg;
    logic       idle;
    logic       hw_lock_now;
    logic       mem_ok;
    logic       sts_ok;

    seph_pause u_pause (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_sel_n   (i_sel_n),
        .i_sck     (i_sck),
        .i_hold_n  (i_hold_n),
        .o_paused  (paused)
    );

    // ------------------------------------------------------------
    // Protection decision
    // ------------------------------------------------------------
    assign idle        = (st_reg == seph_pkg::SEPH_IDLE);
    assign hw_lock_now = lock_reg & ~i_wp_n;
    // Requests only count while selected, not paused and supply good
    assign mem_ok = idle & wel_reg & ~i_sel_n & ~paused & ~i_low_supply
                  & ~addr_protected(psz_reg, i_mem_wr_addr);
    // Pin level sampled here, at acceptance, so later pin moves do not matter
    assign sts_ok = idle & wel_reg & ~i_sel_n & ~paused & ~i_low_supply
                  & ~hw_lock_now;

    // ------------------------------------------------------------
    // Write engine
    // ------------------------------------------------------------
    // Busy is kept in its own flop so the output needs no decode of the state
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_reg   <= seph_pkg::SEPH_IDLE;
            busy_reg <= 1'b0;
        end else if (i_low_supply) begin
            st_reg   <= seph_pkg::SEPH_IDLE;
            busy_reg <= 1'b0;
        end else begin
            case (st_reg)
                seph_pkg::SEPH_IDLE: begin
                    if (i_mem_wr_req && mem_ok) begin
                        st_reg   <= seph_pkg::SEPH_MEM_WR;
                        busy_reg <= 1'b1;
                    end else if (i_sts_wr_req && !i_mem_wr_req && sts_ok) begin
                        // Memory request wins; a refused one must not let status slip in
                        st_reg   <= seph_pkg::SEPH_STS_WR;
                        busy_reg <= 1'b1;
                    end
                end
                seph_pkg::SEPH_MEM_WR,
                seph_pkg::SEPH_STS_WR: begin
                    if (i_wr_done) begin
                        st_reg   <= seph_pkg::SEPH_IDLE;
                        busy_reg <= 1'b0;
                    end
                end
                default: begin
                    st_reg   <= seph_pkg::SEPH_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pend_lock_reg <= seph_pkg::LOCK_RST;
            pend_psz_reg  <= seph_pkg::PSZ_RST;
        end else if (idle && i_sts_wr_req && sts_ok && !i_mem_wr_req) begin
            pend_lock_reg <= i_sts_lock_new;
            pend_psz_reg  <= i_sts_psz_new;
        end
    end

    // Old values stay visible until the internal write finishes
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            lock_reg <= seph_pkg::LOCK_RST;
            psz_reg  <= seph_pkg::PSZ_RST;
        end else if (st_reg == seph_pkg::SEPH_STS_WR && i_wr_done && !i_low_supply) begin
            lock_reg <= pend_lock_reg;
            psz_reg  <= pend_psz_reg;
        end
    end

    // Latch clears at power trouble, on disable and when any write ends
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_low_supply) begin
            wel_reg <= 1'b0;
        end else if (i_clr_wel || (!idle && i_wr_done)) begin
            wel_reg <= 1'b0;
        end else if (i_set_wel && idle) begin
            wel_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mem_go_reg  <= 1'b0;
            sts_go_reg  <= 1'b0;
            refused_reg <= 1'b0;
            abort_reg   <= 1'b0;
            hw_lock_reg <= 1'b0;
            sw_lock_reg <= 1'b1;
        end else begin
            mem_go_reg  <= idle & i_mem_wr_req & mem_ok & ~i_low_supply;
            sts_go_reg  <= idle & i_sts_wr_req & ~i_mem_wr_req & sts_ok;
            refused_reg <= (i_mem_wr_req & ~mem_ok) | (i_sts_wr_req & ~i_mem_wr_req & ~sts_ok);
            abort_reg   <= i_low_supply & ~idle;
            hw_lock_reg <= hw_lock_now;
            sw_lock_reg <= ~hw_lock_now;
        end
    end

    // ------------------------------------------------------------
    // Serial gating while paused
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sck_int_reg <= 1'b0;
            sdi_int_reg <= 1'b0;
            sdo_reg     <= 1'b0;
            sdo_oe_reg  <= 1'b0;
            sel_q_reg   <= 1'b1;
            sel_end_reg <= 1'b0;
        end else begin
            // Internal clock frozen low, data frozen, output released
            if (!paused) begin
                sck_int_reg <= i_sck & ~i_sel_n;
                sdi_int_reg <= i_sdi;
            end else begin
                sck_int_reg <= 1'b0;
            end
            sdo_reg     <= i_sdo_data;
            sdo_oe_reg  <= i_sdo_drive & ~i_sel_n & ~paused;
            sel_q_reg   <= i_sel_n;
            sel_end_reg <= i_sel_n & ~sel_q_reg;
        end
    end

    assign o_sck_int            = sck_int_reg;
    assign o_sdi_int            = sdi_int_reg;
    assign o_sdo                = sdo_reg;
    assign o_sdo_oe             = sdo_oe_reg;
    assign o_paused             = paused;
    assign o_sel_end            = sel_end_reg;
    assign o_write_enable_latch = wel_reg;
    assign o_status_lock_bit    = lock_reg;
    assign o_protect_size_hi    = psz_reg[1];
    assign o_protect_size_lo    = psz_reg[0];
    assign o_hardware_lock_mode = hw_lock_reg;
    assign o_software_lock_mode = sw_lock_reg;
    assign o_wr_busy            = busy_reg;
    assign o_mem_wr_go          = mem_go_reg;
    assign o_sts_wr_go          = sts_go_reg;
    assign o_wr_refused         = refused_reg;
    assign o_wr_abort           = abort_reg;
endmodule

// File: test/seph_checker.sv
// Port-level assertions for the write-protect and pause block
`timescale 1ns/1ps
module seph_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_sel_n,
    input wire logic        i_sck,
    input wire logic        i_hold_n,
    input wire logic        i_wp_n,
    input wire logic        i_low_supply,
    input wire logic        i_mem_wr_req,
    input wire logic [15:0] i_mem_wr_addr,
    input wire logic        i_wr_done,
    input wire logic        o_sck_int,
    input wire logic        o_sdo_oe,
    input wire logic        o_paused,
    input wire logic        o_sel_end,
    input wire logic        o_write_enable_latch,
    input wire logic        o_status_lock_bit,
    input wire logic        o_protect_size_hi,
    input wire logic        o_protect_size_lo,
    input wire logic        o_hardware_lock_mode,
    input wire logic        o_software_lock_mode,
    input wire logic        o_wr_busy,
    input wire logic        o_mem_wr_go,
    input wire logic        o_sts_wr_go
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [1:0] psz;
    logic       prot;
    assign psz = {o_protect_size_hi, o_protect_size_lo};
    assign prot = (psz == 2'h3) || (psz == 2'h2 && i_mem_wr_addr >= 16'h8000)
                || (psz == 2'h1 && i_mem_wr_addr >= 16'hC000);
    property p_pause_out; o_paused && $past(o_paused) |-> !o_sck_int && !o_sdo_oe; endproperty
    property p_pause_in; !i_hold_n && !i_sck && !i_sel_n |=> o_paused; endproperty
    property p_pause_start; $rose(o_paused) |-> $past(!i_hold_n && !i_sck); endproperty
    property p_sel_end; $rose(i_sel_n) |=> o_sel_end && !o_paused; endproperty
    property p_lock_mode;
        o_hardware_lock_mode == $past(o_status_lock_bit && !i_wp_n)
        && o_software_lock_mode != o_hardware_lock_mode;
    endproperty
    property p_mem_ok;
        i_mem_wr_req && !o_wr_busy && o_write_enable_latch && !i_sel_n && !o_paused
        && !prot && !i_low_supply |=> o_mem_wr_go;
    endproperty
    property p_mem_go;
        o_mem_wr_go |-> $past(o_write_enable_latch && !i_sel_n && !prot && !i_low_supply);
    endproperty
    property p_sts_go;
        o_sts_wr_go |-> $past(o_write_enable_latch && !(o_status_lock_bit && !i_wp_n));
    endproperty
    property p_abort; o_wr_busy && i_low_supply |=> !o_wr_busy && !o_write_enable_latch; endproperty
    property p_fields; !i_wr_done |=> $stable({o_status_lock_bit, psz}); endproperty
    a_pause_out: assert property (p_pause_out) else $error("output active in pause");
    a_pause_in: assert property (p_pause_in) else $error("pause not entered");
    a_pause_start: assert property (p_pause_start) else $error("pause began early");
    a_sel_end: assert property (p_sel_end) else $error("deselect kept state");
    a_lock_mode: assert property (p_lock_mode) else $error("lock mode wrong");
    a_mem_ok: assert property (p_mem_ok) else $error("legal write refused");
    a_mem_go: assert property (p_mem_go) else $error("illegal write run");
    a_sts_go: assert property (p_sts_go) else $error("locked status run");
    a_abort: assert property (p_abort) else $error("low supply no abort");
    a_fields: assert property (p_fields) else $error("fields moved early");
    c_mem: cover property (o_mem_wr_go);
    c_sts: cover property (o_sts_wr_go);
    c_pause: cover property ($rose(o_paused));
    c_abort: cover property (o_wr_busy && i_low_supply);
endmodule
bind seph_top seph_checker seph_checker_inst (.*);

// File: test/seph_host.sv
// Serial host model driving select, clock, data and pause
`timescale 1ns/1ps
module seph_host (
    input  wire logic i_ref_clk,
    output logic      o_sel_n = 1'b1,
    output logic      o_sck = 1'b0,
    output logic      o_sdi = 1'b1,
    output logic      o_hold_n = 1'b1
);
    // Data toggles each cycle so a stale bit never looks like a held one
    always @(negedge i_ref_clk) begin
        o_sdi <= ~o_sdi;
    end
    // Clock stands low outside frames and never rises without select
    // Callers keep select low while pausing, except a deliberate abort
    task automatic drive(input logic sel, input logic sck, input logic hold);
        @(negedge i_ref_clk);
        o_sck    = sck & sel;
        o_sel_n  = ~sel;
        o_hold_n = ~hold;
    endtask
endmodule

// File: test/seph_top_tb.sv
// Self-checking bench for the write-protect and pause block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_fail++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, gt); end end
module seph_top_tb;
    logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wp_n = 1'b1, i_low_supply = 1'b0;
    logic        i_set_wel = 1'b0, i_clr_wel = 1'b0, i_mem_wr_req = 1'b0, i_sts_wr_req = 1'b0;
    logic        i_sts_lock_new = 1'b0, i_wr_done = 1'b0, i_sdo_data = 1'b1, i_sdo_drive = 1'b1;
    logic [15:0] i_mem_wr_addr = 16'h0000;
    logic [1:0]  i_sts_psz_new = 2'h0;
    logic        i_sel_n, i_sck, i_sdi, i_hold_n, o_sck_int, o_sdi_int, o_sdo, o_sdo_oe;
    logic        o_paused, o_sel_end, o_write_enable_latch, o_status_lock_bit, o_wr_busy;
    logic        o_protect_size_hi, o_protect_size_lo, o_hardware_lock_mode, o_wr_abort;
    logic        o_software_lock_mode, o_mem_wr_go, o_sts_wr_go, o_wr_refused;
    int          n_fail = 0, num_checks = 0;
    logic [15:0] lo [4] = '{16'h0000, 16'hBFFF, 16'h7FFF, 16'h0000};
    logic [15:0] hi [4] = '{16'hFFFF, 16'hC000, 16'h8000, 16'h0000};
    always #20 i_ref_clk = ~i_ref_clk;
    seph_top seph_top_inst (.*);
    seph_host seph_host_inst (.i_ref_clk(i_ref_clk), .o_sel_n(i_sel_n), .o_sck(i_sck),
                              .o_sdi(i_sdi), .o_hold_n(i_hold_n));
    task automatic tick(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic set_wp(input logic v);
        tick(1);
        i_wp_n = v;
    endtask
    // One write: optional latch set, request, verdict, then done or latch clear
    task automatic wr(input logic sts, input logic write_enable_latch, input logic [15:0] a,
                      input logic [2:0] f, input logic ok);
        tick(1);
        i_set_wel = write_enable_latch;
        tick(1);
        i_set_wel = 1'b0;
        {i_sts_wr_req, i_mem_wr_req} = {sts, ~sts};
        i_mem_wr_addr = a;
        {i_sts_lock_new, i_sts_psz_new} = f;
        tick(1);
        {i_sts_wr_req, i_mem_wr_req} = 2'h0;
        `CHK("go", ok, sts ? o_sts_wr_go : o_mem_wr_go)
        `CHK("refused", ~ok, o_wr_refused)
        i_wr_done = ok;
        i_clr_wel = ~ok;
        tick(1);
        {i_wr_done, i_clr_wel} = 2'h0;
        tick(1);
        `CHK("busy", 1'b0, o_wr_busy)
        `CHK("wel", 1'b0, o_write_enable_latch)
    endtask
    task automatic t_protect;
        wr(1'b0, 1'b0, 16'h0000, 3'h0, 1'b0);
        wr(1'b1, 1'b0, 16'h0000, 3'h1, 1'b0);
        for (int p = 0; p < 4; p++) begin
            wr(1'b1, 1'b1, 16'h0000, 3'(p), 1'b1);
            `CHK("psz", 2'(p), {o_protect_size_hi, o_protect_size_lo})
            wr(1'b0, 1'b1, lo[p], 3'h0, p != 3);
            wr(1'b0, 1'b1, hi[p], 3'h0, p == 0);
        end
        wr(1'b1, 1'b1, 16'h0000, 3'h0, 1'b1);
    endtask
    task automatic t_lock;
        wr(1'b1, 1'b1, 16'h0000, 3'h4, 1'b1);
        set_wp(1'b0);
        tick(2);
        `CHK("hlm", 1'b1, o_hardware_lock_mode)
        `CHK("slm", 1'b0, o_software_lock_mode)
        wr(1'b1, 1'b1, 16'h0000, 3'h0, 1'b0);
        wr(1'b0, 1'b1, 16'h0000, 3'h0, 1'b1);
        set_wp(1'b1);
        wr(1'b1, 1'b1, 16'h0000, 3'h0, 1'b1);
        `CHK("lock", 1'b0, o_status_lock_bit)
        set_wp(1'b0);
        wr(1'b1, 1'b1, 16'h0000, 3'h4, 1'b1);
        wr(1'b1, 1'b1, 16'h0000, 3'h0, 1'b0);
        set_wp(1'b1);
        wr(1'b1, 1'b1, 16'h0000, 3'h0, 1'b1);
        // Pin drops after acceptance: the write still runs with the old level
        wr(1'b1, 1'b1, 16'h0000, 3'h4, 1'b1);
        tick(1);
        i_set_wel = 1'b1;
        tick(1);
        i_set_wel = 1'b0;
        i_sts_wr_req = 1'b1;
        {i_sts_lock_new, i_sts_psz_new} = 3'h0;
        tick(1);
        i_sts_wr_req = 1'b0;
        i_wp_n = 1'b0;
        `CHK("go", 1'b1, o_sts_wr_go)
        i_wr_done = 1'b1;
        tick(1);
        i_wr_done = 1'b0;
        i_wp_n = 1'b1;
        tick(1);
        `CHK("lock", 1'b0, o_status_lock_bit)
    endtask
    task automatic t_supply;
        tick(1);
        i_set_wel = 1'b1;
        tick(1);
        i_set_wel = 1'b0;
        i_mem_wr_req = 1'b1;
        tick(1);
        i_mem_wr_req = 1'b0;
        i_low_supply = 1'b1;
        tick(1);
        i_low_supply = 1'b0;
        `CHK("abort", 1'b1, o_wr_abort)
        `CHK("busy", 1'b0, o_wr_busy)
        `CHK("wel", 1'b0, o_write_enable_latch)
        wr(1'b0, 1'b0, 16'h0000, 3'h0, 1'b0);
        wr(1'b0, 1'b1, 16'h0000, 3'h0, 1'b1);
    endtask
    // Pause with clock low and high, then a deselect while paused
    task automatic t_pause;
        logic sdi_seen;
        i_sdo_data = 1'b0;
        `CHK("oe", 1'b1, o_sdo_oe)
        seph_host_inst.drive(1'b1, 1'b0, 1'b1);
        tick(1);
        `CHK("paused", 1'b1, o_paused)
        `CHK("sdo", 1'b0, o_sdo)
        sdi_seen = o_sdi_int;
        seph_host_inst.drive(1'b1, 1'b1, 1'b1);
        `CHK("sdi", sdi_seen, o_sdi_int)
        tick(1);
        `CHK("sck", 1'b0, o_sck_int)
        `CHK("oe", 1'b0, o_sdo_oe)
        seph_host_inst.drive(1'b1, 1'b1, 1'b0);
        tick(1);
        `CHK("paused", 1'b1, o_paused)
        seph_host_inst.drive(1'b1, 1'b0, 1'b0);
        tick(1);
        `CHK("paused", 1'b0, o_paused)
        seph_host_inst.drive(1'b1, 1'b1, 1'b1);
        tick(1);
        `CHK("paused", 1'b0, o_paused)
        seph_host_inst.drive(1'b1, 1'b0, 1'b1);
        tick(1);
        `CHK("paused", 1'b1, o_paused)
        seph_host_inst.drive(1'b0, 1'b0, 1'b1);
        tick(1);
        `CHK("paused", 1'b0, o_paused)
        `CHK("sel_end", 1'b1, o_sel_end)
        wr(1'b0, 1'b1, 16'h0000, 3'h0, 1'b0);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(3);
        i_rst = 1'b0;
        seph_host_inst.drive(1'b1, 1'b0, 1'b0);
        t_protect;
        t_lock;
        t_supply;
        t_pause;
        final_report;
    end
    initial begin
        #(40 * 3000);
        n_fail++;
        final_report;
    end
endmodule
